// file: rtl/fdmc_dev.sv
// Purpose: flash data memory control, device end
// Assumes: core issues nothing but core_rst while stall is high
// Notes:   core_rst is a device reset that keeps the abort flag
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "fdmc_defs.svh"
// Contract
// R01 - read bit set fetches addressed byte
// R02 - data byte holds until read or write
// R03 - read stalls core, resumes next instruction
// R04 - read starts only by single-bit set
// R05 - eight rows of eight bytes
// R06 - erase/program need exact unlock sequence
// R07 - erase: address, erase select, enable, trigger
// R08 - erase select cleared if enable not next
// R09 - enable cleared if trigger not next
// R10 - erase stalls core, resumes next instruction
// R11 - enable and trigger only by bit sets
// R12 - erase row from address bits 5:3
// R13 - write: address, data, enable, trigger
// R14 - no padding instruction needed after trigger
// R15 - address bits 5:0, top reads zero
// R16 - erase select bit cleared after erase
// R17 - abort flag set by reset mid-program
// R18 - enable bit permits program cycles
// R19 - trigger starts cycle, reads zero after
// R20 - read bit starts read, top zero
// R21 - no protection blocks array access
// R22 - program time is parameterised stall count
module fdmc_dev
  import fdmc_pkg::*;
#(
  parameter int PROG_CYC = `FDMC_PROG_NS / `FDMC_CLK_NS
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // core link
  fdmc_if.dev       lnk,
  // status
  output logic      prog_busy
);
  import fdmc_pkg::*;

  fdmc_state_t      state_ff, nxt_state;
  logic [31:0]      cnt_ff, nxt_cnt;
  logic [7:0]       data_ff, nxt_data;
  logic [5:0]       addr_ff, nxt_addr;
  logic             rd_ff, nxt_rd;
  logic             wr_ff, nxt_wr;
  logic             en_ff, nxt_en;
  logic             abort_ff, nxt_abort;
  logic             erase_ff, nxt_erase;
  logic             pv_erase_ff, nxt_pv_erase;
  logic             pv_en_ff, nxt_pv_en;
  logic [7:0]       rdata_ff, nxt_rdata;
  logic             rvalid_ff, nxt_rvalid;
  logic             stall_ff, nxt_stall;
  logic             arr_prog, arr_erase;
  logic [7:0]       arr_rdata;

  function automatic logic bset(input logic [2:0] b);
    bset = lnk.instr && lnk.kind == FDMC_BSET && lnk.rsel == `FDMC_SEL_CTRL && lnk.bsel == b;
  endfunction

  function automatic logic wreg(input logic [1:0] s);
    wreg = lnk.instr && lnk.kind == FDMC_WRITE && lnk.rsel == s;
  endfunction

  fdmc_array #(
    .AW(`FDMC_AW)
  ) u_array (
    .pclk  (pclk),
    .prog  (arr_prog),
    .erase (arr_erase),
    .addr  (addr_ff),
    .wdata (data_ff),
    .rdata (arr_rdata)
  );

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_data     = data_ff;
    nxt_addr     = addr_ff;
    nxt_rd       = rd_ff;
    nxt_wr       = wr_ff;
    nxt_en       = en_ff;
    nxt_abort    = abort_ff;
    nxt_erase    = erase_ff;
    nxt_pv_erase = pv_erase_ff;
    nxt_pv_en    = pv_en_ff;
    nxt_rdata    = rdata_ff;
    nxt_rvalid   = 1'b0;
    arr_prog     = 1'b0;
    arr_erase    = 1'b0;
    case (state_ff)
      FDMC_IDLE:
      begin
        if (lnk.instr)
        begin
          // sequence watch: each instruction is one instruction cycle
          nxt_pv_erase = 1'b0;
          nxt_pv_en    = 1'b0;
          if (pv_erase_ff && !bset(`FDMC_B_EN))
            nxt_erase = 1'b0; // [R08]
          if (pv_en_ff && !bset(`FDMC_B_WR))
            nxt_en = 1'b0; // [R09]
          // plain register writes
          if (wreg(`FDMC_SEL_DATA))
            nxt_data = lnk.wdata; // [R02] [R13]
          if (wreg(`FDMC_SEL_ADDR))
            nxt_addr = lnk.wdata[`FDMC_AW-1:0]; // [R15]
          if (wreg(`FDMC_SEL_CTRL))
          begin
            // a control register write may set erase select; enable only cleared
            nxt_erase    = lnk.wdata[`FDMC_B_ERASE]; // [R11]
            nxt_pv_erase = lnk.wdata[`FDMC_B_ERASE];
            nxt_abort    = lnk.wdata[`FDMC_B_ABORT];
            nxt_en       = en_ff && lnk.wdata[`FDMC_B_EN] && !pv_en_ff;
          end
          // single-bit sets on the control register
          if (bset(`FDMC_B_ERASE))
          begin
            nxt_erase    = 1'b1; // [R07]
            nxt_pv_erase = 1'b1;
          end
          if (bset(`FDMC_B_ABORT))
            nxt_abort = 1'b1;
          if (bset(`FDMC_B_EN))
          begin
            nxt_en    = 1'b1; // [R11] [R13]
            nxt_pv_en = 1'b1;
          end
          if (bset(`FDMC_B_WR) && pv_en_ff && en_ff)
          begin
            // unlock complete, enable permits the cycle
            nxt_wr    = 1'b1; // [R06] [R18] [R19] [R21]
            nxt_state = FDMC_PROG;
            nxt_cnt   = 32'(PROG_CYC); // [R22]
          end
          if (bset(`FDMC_B_RD))
          begin
            nxt_rd    = 1'b1; // [R04] [R20]
            nxt_state = FDMC_RDCYC; // [R03]
          end
          if (lnk.instr && lnk.kind == FDMC_READ)
          begin
            nxt_rvalid = 1'b1;
            case (lnk.rsel)
              `FDMC_SEL_DATA: nxt_rdata = data_ff;
              `FDMC_SEL_ADDR: nxt_rdata = {2'h0, addr_ff}; // [R15]
              `FDMC_SEL_CTRL: nxt_rdata = {3'h0, erase_ff, abort_ff, en_ff, wr_ff, rd_ff}; // [R20]
              default:        nxt_rdata = 8'h00;
            endcase
          end
        end
      end
      FDMC_RDCYC:
      begin
        nxt_data  = arr_rdata; // [R01] [R02]
        nxt_rd    = 1'b0; // [R20]
        nxt_state = FDMC_IDLE; // [R14]
      end
      FDMC_PROG:
      begin
        nxt_cnt = cnt_ff - 32'h1;
        if (cnt_ff <= 32'h1)
        begin
          arr_erase = erase_ff; // [R12] [R16]
          arr_prog  = !erase_ff; // [R13]
          nxt_erase = 1'b0; // [R16]
          nxt_wr    = 1'b0; // [R19]
          nxt_state = FDMC_IDLE; // [R10] [R14]
        end
      end
      default: nxt_state = FDMC_IDLE;
    endcase
    if (lnk.core_rst)
    begin
      // device reset: operation cut short, flag survives
      nxt_abort    = abort_ff || (state_ff == FDMC_PROG); // [R17]
      nxt_state    = FDMC_IDLE;
      nxt_wr       = 1'b0;
      nxt_rd       = 1'b0;
      nxt_en       = 1'b0;
      nxt_erase    = 1'b0;
      nxt_pv_erase = 1'b0;
      nxt_pv_en    = 1'b0;
      arr_prog     = 1'b0;
      arr_erase    = 1'b0;
    end
    nxt_stall = (nxt_state != FDMC_IDLE); // [R03] [R10] [R13]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff    <= FDMC_IDLE;
      cnt_ff      <= 32'h0;
      data_ff     <= 8'h00;
      addr_ff     <= 6'h00;
      rd_ff       <= 1'b0;
      wr_ff       <= 1'b0;
      en_ff       <= 1'b0;
      abort_ff    <= 1'b0;
      erase_ff    <= 1'b0;
      pv_erase_ff <= 1'b0;
      pv_en_ff    <= 1'b0;
      rdata_ff    <= 8'h00;
      rvalid_ff   <= 1'b0;
      stall_ff    <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      data_ff     <= nxt_data;
      addr_ff     <= nxt_addr;
      rd_ff       <= nxt_rd;
      wr_ff       <= nxt_wr;
      en_ff       <= nxt_en;
      abort_ff    <= nxt_abort;
      erase_ff    <= nxt_erase;
      pv_erase_ff <= nxt_pv_erase;
      pv_en_ff    <= nxt_pv_en;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
      stall_ff    <= nxt_stall;
    end
  end

  assign lnk.rdata  = rdata_ff;
  assign lnk.rvalid = rvalid_ff;
  assign lnk.stall  = stall_ff;
  assign prog_busy  = wr_ff;
endmodule

// file: rtl/fdmc_defs.svh
// Purpose: constants of the flash data memory controller
// Assumes: 100 MHz pclk
// Notes:   definitions only
`ifndef FDMC_DEFS_SVH
`define FDMC_DEFS_SVH
// register selects on the core side
`define FDMC_SEL_DATA 2'h0
`define FDMC_SEL_ADDR 2'h1
`define FDMC_SEL_CTRL 2'h2
// control bit positions
`define FDMC_B_RD    3'h0
`define FDMC_B_WR    3'h1
`define FDMC_B_EN    3'h2
`define FDMC_B_ABORT 3'h3
`define FDMC_B_ERASE 3'h4
// array shape
`define FDMC_AW      6
`define FDMC_ROW_LSB 3
`define FDMC_ROW_LEN 8
`define FDMC_ERASED  8'hFF
// timing
`define FDMC_CLK_NS  10
`define FDMC_PROG_NS 2000000
// apb map of the core-side controller
`define FDMC_A_CMD   12'h000
`define FDMC_A_STAT  12'h004
`define FDMC_A_RST   12'h008
`endif

// file: rtl/fdmc_pkg.sv
// Purpose: shared types of the flash data memory controller
// Assumes: nothing
// Notes:   kind encoding is also the apb command field
package fdmc_pkg;
  typedef enum logic [1:0] {FDMC_NOP, FDMC_WRITE, FDMC_BSET, FDMC_READ} fdmc_kind_t;
  typedef enum logic [1:0] {FDMC_IDLE, FDMC_RDCYC, FDMC_PROG} fdmc_state_t;
endpackage

// file: rtl/fdmc_if.sv
// Purpose: core to flash data memory link
// Assumes: one clock, pclk
// Notes:   one instruction per instr pulse
`timescale 1ns/1ps
interface fdmc_if;
  import fdmc_pkg::*;
  logic       instr;
  fdmc_kind_t kind;
  logic [1:0] rsel;
  logic [2:0] bsel;
  logic [7:0] wdata;
  logic       core_rst;
  logic [7:0] rdata;
  logic       rvalid;
  logic       stall;
  modport dev  (input instr, kind, rsel, bsel, wdata, core_rst,
                output rdata, rvalid, stall);
  modport core (output instr, kind, rsel, bsel, wdata, core_rst,
                input rdata, rvalid, stall);
endinterface

// file: rtl/fdmc_array.sv
// Purpose: 64 byte nonvolatile array, byte program and row erase
// Assumes: at most one of prog and erase per cycle
// Notes:   read is combinational
`timescale 1ns/1ps
`include "fdmc_defs.svh"
module fdmc_array #(
  parameter int AW = `FDMC_AW
) (
  // clock
  input  wire logic          pclk,
  // operations
  input  wire logic          prog,
  input  wire logic          erase,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [2**AW];
  logic [AW-1:0] row_base;

  assign row_base = {addr[AW-1:`FDMC_ROW_LSB], {`FDMC_ROW_LSB{1'b0}}};
  assign rdata    = mem[addr];

  // row erase or byte program
  always_ff @(posedge pclk)
  begin
    if (erase)
    begin
      for (int i = 0; i < `FDMC_ROW_LEN; i++)
        mem[row_base + AW'(i)] <= `FDMC_ERASED; // [R05] [R12]
    end
    else if (prog)
      mem[addr] <= wdata; // [R05]
  end
endmodule

// file: rtl/fdmc_core.sv
// Purpose: core end, turns apb commands into link instructions
// Assumes: one apb master
// Notes:   command write waits in access phase while stalled
`timescale 1ns/1ps
`include "fdmc_defs.svh"
module fdmc_core
  import fdmc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  fdmc_if.core             lnk
);
  import fdmc_pkg::*;

  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        instr_ff, nxt_instr;
  fdmc_kind_t  kind_ff, nxt_kind;
  logic [1:0]  rsel_ff, nxt_rsel;
  logic [2:0]  bsel_ff, nxt_bsel;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        crst_ff, nxt_crst;
  logic [7:0]  last_ff, nxt_last;
  logic        access;

  assign access = psel && penable && !pready_ff;

  always_comb
  begin
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    nxt_instr   = 1'b0;
    nxt_kind    = kind_ff;
    nxt_rsel    = rsel_ff;
    nxt_bsel    = bsel_ff;
    nxt_wdata   = wdata_ff;
    nxt_crst    = 1'b0;
    nxt_last    = lnk.rvalid ? lnk.rdata : last_ff;
    if (access)
    begin
      case (paddr)
        `FDMC_A_CMD:
        begin
          // one instruction per command, never while stalled
          if (!pwrite)
          begin
            nxt_pready = 1'b1;
            nxt_prdata = 32'h0;
          end
          else if (!lnk.stall && !instr_ff) // [R14]
          begin
            nxt_pready = 1'b1;
            nxt_instr  = 1'b1; // [R06] [R07] [R13]
            nxt_kind   = fdmc_kind_t'(pwdata[1:0]); // [R04]
            nxt_rsel   = pwdata[3:2];
            nxt_bsel   = pwdata[6:4];
            nxt_wdata  = pwdata[15:8];
          end
        end
        `FDMC_A_STAT:
        begin
          nxt_pready = 1'b1;
          nxt_prdata = {16'h0, last_ff, 7'h0, lnk.stall};
        end
        `FDMC_A_RST:
        begin
          nxt_pready = 1'b1;
          nxt_prdata = 32'h0;
          nxt_crst   = pwrite && pwdata[0];
        end
        default:
        begin
          nxt_pready  = 1'b1;
          nxt_pslverr = 1'b1;
          nxt_prdata  = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
      instr_ff   <= 1'b0;
      kind_ff    <= FDMC_NOP;
      rsel_ff    <= 2'h0;
      bsel_ff    <= 3'h0;
      wdata_ff   <= 8'h00;
      crst_ff    <= 1'b0;
      last_ff    <= 8'h00;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      instr_ff   <= nxt_instr;
      kind_ff    <= nxt_kind;
      rsel_ff    <= nxt_rsel;
      bsel_ff    <= nxt_bsel;
      wdata_ff   <= nxt_wdata;
      crst_ff    <= nxt_crst;
      last_ff    <= nxt_last;
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign lnk.instr    = instr_ff;
  assign lnk.kind     = kind_ff;
  assign lnk.rsel     = rsel_ff;
  assign lnk.bsel     = bsel_ff;
  assign lnk.wdata    = wdata_ff;
  assign lnk.core_rst = crst_ff;
endmodule

// file: tb/fdmc_monitor.sv
// Purpose: link checker for the flash data memory controller
// Assumes: one clock, async active-low reset
// Notes:   watches the interface signals only
`timescale 1ns/1ps
module fdmc_monitor #(
  parameter int PROG_CYC = 5
) (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // link
  input wire logic                instr,
  input wire fdmc_pkg::fdmc_kind_t kind,
  input wire logic [1:0]          rsel,
  input wire logic [2:0]          bsel,
  input wire logic                core_rst,
  input wire logic [7:0]          rdata,
  input wire logic                rvalid,
  input wire logic                stall
);
  import fdmc_pkg::*;
  logic        rd_ff;
  logic        nxt_rd;
  logic        en_ff;
  logic        nxt_en;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        bset_c;
  // last instruction tracking and stall length
  always_comb
  begin
    bset_c  = instr && kind == FDMC_BSET && rsel == 2'h2;
    nxt_rd  = instr && kind == FDMC_READ;
    nxt_en  = core_rst ? 1'b0 : (instr ? bset_c && bsel == 3'h2 : en_ff);
    nxt_cnt = stall ? cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ff  <= 1'b0;
      en_ff  <= 1'b0;
      cnt_ff <= 32'h0;
    end
    else
    begin
      rd_ff  <= nxt_rd;
      en_ff  <= nxt_en;
      cnt_ff <= nxt_cnt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  read_answer_a: assert property (rvalid == rd_ff)
    else $error("rvalid not one cycle after read");
  read_stall_a: assert property (bset_c && bsel == 3'h0 |=> stall ##1 !stall)
    else $error("read stall not one cycle");
  data_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("rdata moved without read");
  lone_trig_a: assert property (bset_c && bsel == 3'h1 && !en_ff |=> !stall)
    else $error("trigger out of sequence started a cycle");
  unlock_trig_a: assert property (bset_c && bsel == 3'h1 && en_ff |=> stall ##1 stall)
    else $error("unlocked trigger did not stall");
  plain_write_a: assert property (instr && kind == FDMC_WRITE |=> !stall)
    else $error("plain write started a cycle");
  stall_cause_a: assert property ($rose(stall) |-> $past(instr))
    else $error("stall without instruction");
  prog_len_a: assert property (stall |-> cnt_ff < PROG_CYC)
    else $error("stall longer than program count");
endmodule

// file: tb/fdmc_tb.sv
// Purpose: testbench of the flash data memory controller
// Assumes: apb master, 100 MHz pclk
// Notes:   program count shortened to 5
`timescale 1ns/1ps
`include "fdmc_defs.svh"
module fdmc_tb;
  import fdmc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        prog_busy;
  logic [31:0] rd_q;
  logic        err_q;
  int          bad_count;
  int          num_checks;
  fdmc_if lnk();
  fdmc_core fdmc_core_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  fdmc_dev #(.PROG_CYC(5)) fdmc_dev_inst(.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .prog_busy(prog_busy));
  fdmc_monitor #(.PROG_CYC(5)) fdmc_monitor_inst(.pclk(pclk), .presetn(presetn),
    .instr(lnk.instr), .kind(lnk.kind), .rsel(lnk.rsel), .bsel(lnk.bsel),
    .core_rst(lnk.core_rst), .rdata(lnk.rdata), .rvalid(lnk.rvalid), .stall(lnk.stall));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input fdmc_kind_t k, input logic [1:0] r, input logic [2:0] b,
                     input logic [7:0] d);
    apb(1'b1, `FDMC_A_CMD, {16'h0000, d, 1'b0, b, r, k});
  endtask
  task automatic rreg(input logic [1:0] r, input string nm, input logic [7:0] e);
    cmd(FDMC_READ, r, 3'h0, 8'h00);
    apb(1'b0, `FDMC_A_STAT, 32'h0);
    chk(nm, {24'h0, e}, {24'h0, rd_q[15:8]});
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'hFF);
    rreg(`FDMC_SEL_ADDR, "addr", 8'h3F);
    $display("test reset and address done");
    // row erase via unlock sequence
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'h0A);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_ERASE, 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_EN, 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_WR, 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'h0F);
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h04);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_RD, 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'hFF);
    $display("test erase done");
    // byte program
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'h0A);
    cmd(FDMC_WRITE, `FDMC_SEL_DATA, 3'h0, 8'h5A);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_EN, 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_WR, 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_DATA, 3'h0, 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_RD, 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'h5A);
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'h0B);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_RD, 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'hFF);
    $display("test program done");
    // broken sequences
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_ERASE, 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_ADDR, 3'h0, 8'h0A);
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h04);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_EN, 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_DATA, 3'h0, 8'h33);
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_WR, 8'h00);
    cmd(FDMC_WRITE, `FDMC_SEL_CTRL, 3'h0, 8'h07);
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_RD, 8'h00);
    rreg(`FDMC_SEL_DATA, "data", 8'h5A);
    $display("test sequence guard done");
    // device reset in mid program
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_EN, 8'h00);
    cmd(FDMC_BSET, `FDMC_SEL_CTRL, `FDMC_B_WR, 8'h00);
    chk("prog_busy", 32'h1, {31'h0, prog_busy});
    apb(1'b1, `FDMC_A_RST, 32'h1);
    chk("prog_busy", 32'h0, {31'h0, prog_busy});
    rreg(`FDMC_SEL_CTRL, "ctrl", 8'h08);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err_q});
    $display("test abort and unmapped done");
    tally_and_finish();
  end
endmodule
